/* File: src/sar_readout.sv */
// design: control and serial readout of the converter
`timescale 1ns/10ps
`default_nettype none

module sar_readout #(
    parameter int RES_BITS = sar_pkg::RES_BITS
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                resetn,
    // host pins
    input  wire logic                conversion_strobe,
    input  wire logic                sclk,
    input  wire logic                sdi,
    input  wire logic                fast_mode,
    // converter core
    input  wire logic [RES_BITS-1:0] core_result,
    output logic                     core_sample,
    output logic                     core_power_on,
    // serial output
    output logic                     sdo,
    output logic                     sdo_oe,
    // status
    output logic                     busy,
    output logic                     chain_mode
);
    // =========================================================
    // input synchronisers: two flops per pin
    logic cnv_s;
    logic sck_s;
    logic sdi_s;
    logic fast_s;
    logic cnv_q;
    logic sck_q;

    sar_sync u_sync_cnv (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pin     (conversion_strobe),
        .level   (cnv_s)
    );

    sar_sync u_sync_sck (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pin     (sclk),
        .level   (sck_s)
    );

    sar_sync u_sync_sdi (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pin     (sdi),
        .level   (sdi_s)
    );

    sar_sync u_sync_fast (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pin     (fast_mode),
        .level   (fast_s)
    );

    // edge detect flops behind the synchronisers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnv_q <= 1'b0;
            sck_q <= 1'b0;
        end else begin
            cnv_q <= cnv_s;
            sck_q <= sck_s;
        end
    end

    wire cnv_rise  = cnv_s & ~cnv_q;
    wire sck_fall  = ~sck_s & sck_q;
    wire sck_rise  = sck_s & ~sck_q;

    // =========================================================
    // conversion timer on the system clock
    localparam int CW = 8;
    localparam logic [CW-1:0] CYC_FAST = CW'(sar_pkg::CONV_CYC_FAST);
    localparam logic [CW-1:0] CYC_NORM = CW'(sar_pkg::CONV_CYC_NORM);

    sar_pkg::sar_state_e state_q, state_d;
    logic [CW-1:0]       cnt_q, cnt_d;
    logic                chain_q, chain_d;
    logic                turbo_q, turbo_d;
    logic                busy_en_q, busy_en_d;

    wire conv_done = (state_q == sar_pkg::SAR_CONV) && (cnt_q == '0);
    wire sel_cs    = ~sdi_s | ~cnv_s;

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        chain_d   = chain_q;
        turbo_d   = turbo_q;
        busy_en_d = busy_en_q;
        case (state_q)
            sar_pkg::SAR_IDLE, sar_pkg::SAR_READ: begin
                if (cnv_rise) begin
                    state_d   = sar_pkg::SAR_CONV;
                    chain_d   = ~sdi_s;
                    turbo_d   = fast_s;
                    busy_en_d = 1'b0;
                    cnt_d     = (fast_s ? CYC_FAST : CYC_NORM) - CW'(1);
                end
            end
            sar_pkg::SAR_CONV: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - CW'(1);
                end else begin
                    state_d   = sar_pkg::SAR_READ;
                    busy_en_d = ~chain_q & sel_cs;
                end
            end
            default: state_d = sar_pkg::SAR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q   <= sar_pkg::SAR_IDLE;
            cnt_q     <= '0;
            chain_q   <= 1'b0;
            turbo_q   <= 1'b0;
            busy_en_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            chain_q   <= chain_d;
            turbo_q   <= turbo_d;
            busy_en_q <= busy_en_d;
        end
    end

    // =========================================================
    // result shifter and daisy-chain delay line
    logic [RES_BITS-1:0] shift_q;
    logic                sdo_q;
    wire rd_sel = (state_q == sar_pkg::SAR_READ) && (chain_q || sel_cs);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shift_q <= sar_pkg::RESULT_RST;
            sdo_q   <= 1'b0;
        end else if (conv_done) begin
            shift_q <= core_result;
            sdo_q   <= core_result[RES_BITS-1];
        end else if (rd_sel && sck_rise) begin
            // chain mode shifts in sdi; cs mode shifts in zero
            shift_q <= {shift_q[RES_BITS-2:0], chain_q & sdi_s};
        end else if (rd_sel && sck_fall) begin
            // next bit shown after the host has sampled the last
            sdo_q <= shift_q[RES_BITS-1];
        end
    end

    // =========================================================
    // outputs
    wire in_read = (state_q == sar_pkg::SAR_READ);
    sar_pkg::sar_sdo_s out_w;
    // chain mode drives always; cs mode only while selected
    assign out_w.oe   = chain_q ? 1'b1 : sel_cs;
    // low outside the read state, whether or not the busy indicator is enabled
    assign out_w.data = in_read ? sdo_q : 1'b0;

    assign sdo           = out_w.data;
    assign sdo_oe        = out_w.oe;
    assign busy          = (state_q == sar_pkg::SAR_CONV);
    assign chain_mode    = chain_q;
    // rises during a conversion are refused, no new sample
    assign core_sample   = cnv_rise & ~busy;
    assign core_power_on = turbo_q | fast_s | (state_q == sar_pkg::SAR_CONV);

    wire unused_ok = busy_en_q;
endmodule : sar_readout

// =========================================================
// two-flop synchroniser for one asynchronous pin
module sar_sync (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // pin and its synchronised copy
    input  wire logic pin,
    output logic      level
);
    logic meta_q;
    logic level_q;

    // only the second flop is read by logic
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_q  <= 1'b0;
            level_q <= 1'b0;
        end else begin
            meta_q  <= pin;
            level_q <= meta_q;
        end
    end

    assign level = level_q;
endmodule : sar_sync

`default_nettype wire

/* File: include/sar_pkg.sv */
// package: constants and carriers for the converter readout block
package sar_pkg;
    // =========================================================
    // widths and timing
    localparam int          RES_BITS       = 16;
    localparam int          CHAIN_DELAY    = 16;
    localparam int          CLK_HZ         = 20_000_000;
    // minimum time from strobe rise to result, in ns
    localparam int          CONV_NS_FAST   = 400;
    localparam int          CONV_NS_NORM   = 500;
    localparam int          CONV_CYC_FAST  = (CONV_NS_FAST * (CLK_HZ / 1_000_000)
                                              + 999) / 1000;
    localparam int          CONV_CYC_NORM  = (CONV_NS_NORM * (CLK_HZ / 1_000_000)
                                              + 999) / 1000;
    localparam logic [15:0] RESULT_RST     = 16'h0000;

    // =========================================================
    // state encoding
    typedef enum logic [1:0] {
        SAR_IDLE = 2'b00,
        SAR_CONV = 2'b01,
        SAR_READ = 2'b10
    } sar_state_e;

    // =========================================================
    // serial output carrier
    typedef struct packed {
        logic data;
        logic oe;
    } sar_sdo_s;
endpackage : sar_pkg

/* File: testbench/sar_host_model.sv */
// model: host clocking 32 serial cycles, upstream chain bit source
`timescale 1ns/10ps
`default_nettype none
module sar_host_model (
    input  wire logic        go,
    input  wire logic        sdo,
    input  wire logic [15:0] up,
    output logic             sclk,
    output logic             nb,
    output logic [31:0]      word
);
    logic [15:0] u;
    initial sclk = 1'h0;
    // clock stands low outside frames
    always @(posedge go) begin
        u = up;
        nb = u[15];
        for (int i = 0; i < 32; i++) begin
            #200 sclk = 1'h1;
            word = {word[30:0], sdo};
            #200 sclk = 1'h0;
            u = {u[14:0], ~u[15]};
            nb = u[15];
        end
    end
endmodule : sar_host_model
`default_nettype wire

/* File: testbench/sar_readout_chk.sv */
// checker: timing and output rules of the readout block
`timescale 1ns/10ps
`default_nettype none
module sar_readout_chk #(parameter int RES_BITS = 16) (
    input wire logic                clk_sys, resetn,
    input wire logic                conversion_strobe, sclk, sdi, fast_mode,
    input wire logic [RES_BITS-1:0] core_result,
    input wire logic                core_sample, core_power_on,
    input wire logic                sdo, sdo_oe, busy, chain_mode
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_go; core_sample |=> busy; endproperty
    a_go: assert property (p_go) else $error("no busy");
    property p_len; $rose(busy) |-> busy[*8]; endproperty
    a_len: assert property (p_len) else $error("busy short");
    property p_end; $rose(busy) |-> ##[8:10] !busy; endproperty
    a_end: assert property (p_end) else $error("busy long");
    property p_ch; chain_mode |-> sdo_oe; endproperty
    a_ch: assert property (p_ch) else $error("chain oe");
    property p_on; (!conversion_strobe)[*5] |-> sdo_oe; endproperty
    a_on: assert property (p_on) else $error("oe off");
    property p_off;
        (!chain_mode && conversion_strobe && sdi)[*5] |-> !sdo_oe;
    endproperty
    a_off: assert property (p_off) else $error("oe on");
    property p_bz; busy |-> !sdo; endproperty
    a_bz: assert property (p_bz) else $error("sdo busy");
    property p_st; sclk[*4] |-> $stable(sdo); endproperty
    a_st: assert property (p_st) else $error("sdo moved");
    c_cs: cover property ($fell(busy) && !chain_mode);
    c_cm: cover property ($fell(busy) && chain_mode);
    c_rd: cover property ($rose(sclk) && !busy);
endmodule : sar_readout_chk
bind sar_readout sar_readout_chk #(.RES_BITS(RES_BITS)) u_chk (.clk_sys,
    .resetn, .conversion_strobe, .sclk, .sdi, .fast_mode, .core_result,
    .core_sample, .core_power_on, .sdo, .sdo_oe, .busy, .chain_mode);
`default_nettype wire

/* File: testbench/test_sar_readout.sv */
// testbench: conversions and readout in both interface modes
`timescale 1ns/10ps
`default_nettype none
module test_sar_readout;
    logic        clk_sys = 1'h0, resetn = 1'h0, conversion_strobe = 1'h0;
    logic        sdi_d = 1'h1, fast_mode = 1'h0, sel = 1'h0, go = 1'h0;
    logic [15:0] core_result = 16'h0000, up = 16'h0000;
    logic        sclk, nb, sdo, sdo_oe, busy, chain_mode, core_sample;
    logic        core_power_on;
    logic [31:0] word;
    int          n_mismatch = 0, checks = 0;
    wire         sdi = sel ? nb : sdi_d;
    always #25 clk_sys = ~clk_sys;
    sar_readout dut (.clk_sys, .resetn, .conversion_strobe, .sclk, .sdi,
        .fast_mode, .core_result, .core_sample, .core_power_on, .sdo,
        .sdo_oe, .busy, .chain_mode);
    sar_host_model host (.go, .sdo, .up, .sclk, .nb, .word);
    task automatic chk(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up;
        if (n_mismatch == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic conv(input logic md, fst, input logic [15:0] res);
        int n;
        sdi_d = md;
        fast_mode = fst;
        core_result = res;
        conversion_strobe = 1'h0;
        repeat (4) @(negedge clk_sys);
        conversion_strobe = 1'h1;
        n = 0;
        while (busy !== 1'h1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        n = 0;
        while (busy === 1'h1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        chk(n, fst ? sar_pkg::CONV_CYC_FAST : sar_pkg::CONV_CYC_NORM);
        chk(core_power_on, fst);
        chk(chain_mode, !md);
    endtask : conv
    task automatic t_cs(input logic fst, input logic [15:0] res);
        conv(1'h1, fst, res);
        repeat (6) @(negedge clk_sys);
        chk(sdo_oe, 1'h0);
        conversion_strobe = 1'h0;
        repeat (5) @(negedge clk_sys);
        chk(sdo_oe, 1'h1);
        go = 1'h1;
        repeat (260) @(negedge clk_sys);
        go = 1'h0;
        chk(word[31:16], res);
    endtask : t_cs
    task automatic t_chain(input logic [15:0] res, upv);
        conv(1'h0, 1'h0, res);
        up = upv;
        go = 1'h1;
        sel = 1'h1;
        // strobe held high through the read
        repeat (260) @(negedge clk_sys);
        go = 1'h0;
        sel = 1'h0;
        chk(word, {res, upv});
    endtask : t_chain
    initial begin
        repeat (12) @(negedge clk_sys);
        resetn = 1'h1;
        chk({sdo, busy, chain_mode}, 32'h0);
        // first fast result thrown away
        conv(1'h1, 1'h1, 16'h1234);
        t_cs(1'h1, 16'ha5c3);
        t_cs(1'h0, 16'h8001);
        t_chain(16'h7ffe, 16'hc35a);
        t_cs(1'h0, 16'hffff);
        wrap_up;
    end
    initial begin
        #300000;
        n_mismatch++;
        wrap_up;
    end
endmodule : test_sar_readout
`default_nettype wire
